// ===== bench/mad_ctl_model.sv
`timescale 1ns/1ps
module mad_ctl_model import mad_pkg::*; (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [31:0] o_hwdata
);
  initial begin
    o_haddr = 32'h0;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hwdata = 32'h0;
  end
  // bounded wait for a sampled hready; a hang ends the run as a mismatch
  task automatic wt();
    int n;
    n = 0;
    @(posedge i_clk);
    while (i_hready !== 1'b1) begin
      n++;
      if (n > 16) begin
        testbench.failures++;
        testbench.final_report();
      end
      @(posedge i_clk);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    o_haddr <= {24'h0, a};
    o_hwrite <= w;
    o_htrans <= HTRANS_NONSEQ;
    wt();
    o_htrans <= 2'b00;
    o_hwdata <= d;
    wt();
    q = i_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask
endmodule // mad_ctl_model

// ===== bench/mad_top_sva.sv
`timescale 1ns/1ps
module mad_chk import mad_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic acc;
  logic pend_reg;
  logic [7:0] wa_reg;
  logic [31:0] lo_reg;
  logic [23:0] hi_reg;
  assign acc = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_reg <= 1'b0;
      wa_reg <= 8'h00;
    end else begin
      pend_reg <= acc && i_hwrite;
      wa_reg <= i_haddr[7:0];
    end
  end
  // shadow of the nanoword halves, written at the end of the data phase
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_reg <= 32'h0;
      hi_reg <= 24'h0;
    end else if (pend_reg && wa_reg == ADDR_NANO_LO) begin
      lo_reg <= i_hwdata;
    end else if (pend_reg && wa_reg == ADDR_NANO_HI) begin
      hi_reg <= i_hwdata[23:0];
    end
  end
  sequence s_rd(a);
    acc && !i_hwrite && !pend_reg && i_haddr == {24'h0, a};
  endsequence
  property p_rdy; o_hreadyout == 1'b1; endproperty
  property p_okay; o_hresp == 1'b0; endproperty
  property p_rst; $fell(i_rst) |-> o_hrdata == 32'h0; endproperty
  property p_idle; !acc |=> $stable(o_hrdata); endproperty
  property p_wr; acc && i_hwrite |=> $stable(o_hrdata); endproperty
  property p_unm;
    acc && !i_hwrite && i_haddr inside {[32'h24:32'hfc]} && i_haddr[1:0] == 2'b00 |=> o_hrdata == 32'h0;
  endproperty
  property p_lo; s_rd(ADDR_NANO_LO) |=> o_hrdata == lo_reg; endproperty
  property p_hi; s_rd(ADDR_NANO_HI) |=> o_hrdata[23:0] == hi_reg; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_rst: assert property (p_rst) else $error("read data not cleared by reset");
  a_idle: assert property (p_idle) else $error("read data moved without access");
  a_wr: assert property (p_wr) else $error("read data moved on write");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_lo: assert property (p_lo) else $error("nanoword low readback wrong");
  a_hi: assert property (p_hi) else $error("nanoword high readback wrong");
endmodule // mad_chk
bind mad_top mad_chk mad_chk_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mad_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic hwrite, hready;
  int failures, n_compared;
  mad_xsel_t xs[3] = '{MAD_XS_ACC1, MAD_XS_ACC2, MAD_XS_ACC3};
  initial forever #12.5 clk = ~clk;
  mad_top mad_top_inst (.i_core_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp());
  mad_ctl_model m (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwrite), .o_hwdata(hwdata));
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // first control write runs the previous control word's function and sources with the write-data enables of c, the last one runs c
  task automatic step(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] op, input logic [31:0] c);
    m.wr(ADDR_CTRL, c);
    m.wr(ADDR_NANO_LO, lo);
    m.wr(ADDR_NANO_HI, hi);
    m.wr(ADDR_OPND, op);
    m.wr(ADDR_CTRL, c);
  endtask
  function automatic logic [15:0] f(input logic [3:0] c, input logic [15:0] x, input logic [15:0] y);
    case (c)
      4'h0: f = x + y;
      4'h1: f = ~(x | y);
      4'h2: f = ~x & y;
      4'h3: f = x + y + 16'h1;
      4'h4: f = ~(x & y);
      4'h5: f = x + (x | y);
      4'h6: f = x ^ y;
      4'h7: f = x & ~y;
      4'h8: f = ~x | y;
      4'h9: f = ~(x ^ y);
      4'ha: f = x + (x & y);
      4'hb: f = x & y;
      4'hc: f = x + ~y;
      4'hd: f = x | ~y;
      4'he: f = x | y;
      default: f = x + ~y + 16'h1;
    endcase
  endfunction
  initial begin
    failures = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      step(32'(k) << 27, 32'h0, 32'h00a5_3c0f, {31'h3, k inside {0, 3, 5, 10, 12, 15}});
      m.rd(ADDR_RES, r);
      ck(r[15:0], f(4'(k), 16'h00a5, 16'h3c0f));
    end
    step(32'h0, 32'h0, 32'h00ff_0001, 32'hf);
    m.rd(ADDR_RES, r);
    ck(r[15:0], 16'h0000);
    step(32'h0, 32'h0, 32'h00ff_ff00, 32'h7);
    m.rd(ADDR_STAT, r);
    ck({r[6:4], r[2:1]}, 5'b11010);
    step(32'h0, 32'h0, 32'h00ff_ff01, 32'h7);
    m.rd(ADDR_STAT, r);
    ck({r[6:4], r[2:1]}, 5'b00001);
    // one set bit in the high half gives odd parity, two give even
    step(32'h0, 32'h10, 32'h0, 32'h46);
    m.rd(ADDR_STAT, r);
    ck(r[4:3], 2'b10);
    step(32'h0, 32'h30, 32'h0, 32'h46);
    m.rd(ADDR_STAT, r);
    ck(r[4:3], 2'b11);
    for (int k = 0; k < 3; k++) begin
      step(32'h7000_0000, 32'h0, {8'h00, 8'h5a + 8'(k), 16'h0}, 32'h6 | (32'h1 << (16 + k)));
      step(32'h7000_0000, 32'h0, 32'h0, {29'h0, xs[k], 1'b0});
      m.rd(ADDR_RES, r);
      ck(r[15:0], 16'h005a + 16'(k));
    end
    step(32'h7000_0000, 32'h0, 32'h00ff_0000, 32'h0020_0006);
    m.rd(ADDR_STAT, r);
    ck(r[0], 1'b0);
    step(32'h7000_0000, 32'h0, 32'h0, 32'h0040_0006);
    m.rd(ADDR_STAT, r);
    ck(r[0], 1'b1);
    // both control writes of the step count, so the counter wraps past full to 01
    m.rd(ADDR_RES, r);
    ck(r[15:0], 16'h0100);
    m.rd(ADDR_NANO_LO, r);
    ck(r, 32'h7000_0000);
    m.rd(8'h24, r);
    ck(r, 32'h0);
    m.wr(8'h24, 32'hffff_ffff);
    m.rd(8'h24, r);
    ck(r, 32'h0);
    // increment source follows the control word latched by the previous control write
    m.wr(ADDR_MPM, 32'h0000_0123);
    step(32'h7000_0000, 32'h0, 32'h0, 32'h0000_1100);
    m.rd(ADDR_ALT, r);
    ck(r, 32'h0124_0123);
    step(32'h7000_0000, 32'h0, 32'h0, 32'h0000_0800);
    m.rd(ADDR_ALT, r);
    ck(r, 32'h0125_0123);
    m.rd(ADDR_MPM, r);
    ck(r, 32'h0124_0123);
    final_report();
  end
endmodule // testbench

// ===== verilog/mad_adder.sv
`timescale 1ns/1ps
module mad_adder import mad_pkg::*; (
  input wire logic [WORD_W-1:0] i_x,
  input wire logic [WORD_W-1:0] i_y,
  input wire mad_fn_t i_fn,
  output mad_res_t o_res
);
  logic [WORD_W-1:0] y_eff;
  logic [WORD_W-1:0] logic_out;
  logic [WORD_W:0] lo_sum;
  logic [WORD_W:0] hi_sum;
  logic cin;
  logic [WORD_W-1:0] sum;
  // carry only on the two "+1" operations
  assign cin = i_fn.arith && (i_fn.fn == 4'h3 || i_fn.fn == 4'hf);
  always_comb begin
    y_eff = i_y;
    case (i_fn.fn)
      4'h5: y_eff = i_x | i_y;
      4'ha: y_eff = i_x & i_y;
      4'hc, 4'hf: y_eff = ~i_y;
      default: y_eff = i_y;
    endcase
  end
  always_comb begin
    case (i_fn.fn)
      4'h1: logic_out = ~(i_x | i_y);
      4'h2: logic_out = ~i_x & i_y;
      4'h4: logic_out = ~(i_x & i_y);
      4'h6: logic_out = i_x ^ i_y;
      4'h7: logic_out = i_x & ~i_y;
      4'h8: logic_out = ~i_x | i_y;
      4'h9: logic_out = ~(i_x ^ i_y);
      4'hb: logic_out = i_x & i_y;
      4'hd: logic_out = i_x | ~i_y;
      4'he: logic_out = i_x | i_y;
      default: logic_out = '0;
    endcase
  end
  // low byte and high byte add separately so the byte carry can be gated
  assign lo_sum = {8'h00, 1'b0, i_x[7:0]} + {8'h00, 1'b0, y_eff[7:0]} + {16'h0000, cin};
  assign hi_sum = {1'b0, i_x[15:8], 8'h00} + {1'b0, y_eff[15:8], 8'h00}
    + {8'h00, (lo_sum[8] & ~i_fn.inhibit), 8'h00};
  assign sum = i_fn.arith ? {hi_sum[15:8], lo_sum[7:0]} : logic_out;
  assign o_res.sum = sum;
  assign o_res.ovf = i_fn.arith & hi_sum[16];
  assign o_res.all_true = &sum;
endmodule // mad_adder

// ===== verilog/mad_incr.sv
`timescale 1ns/1ps
module mad_incr import mad_pkg::*; (
  input wire logic [ALT_W-1:0] i_alt,
  input wire logic [ALT_W-1:0] i_mpm,
  input wire logic [1:0] i_alt_plus,
  input wire logic i_borc,
  output logic [ALT_W-1:0] o_next,
  output logic o_valid
);
  always_comb begin
    o_next = '0;
    o_valid = 1'b0;
    if (i_borc) begin
      o_next = i_mpm + 14'h0001;
      o_valid = 1'b1;
    end else if (i_alt_plus != 2'b00) begin
      o_next = i_alt + {12'h000, i_alt_plus};
      o_valid = 1'b1;
    end
  end
endmodule // mad_incr

// ===== verilog/mad_pkg.sv
package mad_pkg;
  localparam int WORD_W = 16;
  localparam int NANO_W = 56;
  localparam int ALT_W = 14;
  localparam int CTR_W = 8;
  localparam int SAR_W = 6;
  // bus register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_RES = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_NANO_LO = 8'h10;
  localparam logic [7:0] ADDR_NANO_HI = 8'h14;
  localparam logic [7:0] ADDR_ALT = 8'h18;
  localparam logic [7:0] ADDR_MPM = 8'h1c;
  localparam logic [7:0] ADDR_CNT = 8'h20;
  // nanoword bit positions (bit n of the nanoword sits at index n-1)
  localparam int NB_FN_LO = 27;
  localparam int NB_BCLK_LO = 36;
  localparam int NB_BCLK_HI = 48;
  localparam int NB_MIR = 40;
  localparam int NB_ALT = 41;
  localparam int NB_BR1 = 42;
  localparam int NB_BR2 = 43;
  // control register fields
  localparam int CF_MODE = 0;
  localparam int CF_XSEL = 1;
  localparam int CF_INH = 3;
  localparam int CF_BC8 = 4;
  localparam int CF_BC4 = 5;
  localparam int CF_TYPE1 = 6;
  localparam int CF_NTEST = 7;
  localparam int CF_ALTMP = 8;
  localparam int CF_ALTMC = 9;
  localparam int CF_APLS = 10;
  localparam int CF_BORC = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [CTR_W-1:0] CTR_FULL = 8'hff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {
    MAD_XS_ACC3 = 2'b00,
    MAD_XS_ACC2 = 2'b01,
    MAD_XS_ACC1 = 2'b10,
    MAD_XS_Z = 2'b11
  } mad_xsel_t;
  typedef struct packed {
    logic arith;
    logic [3:0] fn;
    logic inhibit;
  } mad_fn_t;
  typedef struct packed {
    logic [WORD_W-1:0] sum;
    logic ovf;
    logic all_true;
  } mad_res_t;
endpackage

// ===== verilog/mad_top.sv
`timescale 1ns/1ps
module mad_top import mad_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp
);
  logic [31:0] ctrl_reg;
  logic [31:0] opnd_reg;
  logic [NANO_W-1:0] nano_reg;
  logic [ALT_W-1:0] mpm_reg;
  logic [WORD_W-1:0] acc1_reg, acc2_reg, acc3_reg;
  logic [WORD_W-1:0] b_reg, mir_reg, mar_reg;
  logic [ALT_W-1:0] alt_reg, incr_reg, mpc_reg;
  logic [CTR_W-1:0] ctr_reg, base1_reg, base2_reg;
  logic [SAR_W-1:0] sar_reg;
  logic cov_reg, npe_reg, ovf_reg, abt_reg, shift_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [WORD_W-1:0] x_op, y_op, z_src, barrel;
  mad_fn_t fn;
  mad_res_t res;
  logic [ALT_W-1:0] inc_next;
  logic inc_valid;
  logic b_clk_en;
  logic [WORD_W-1:0] comp_mask;
  logic step;
  logic [31:0] rd_data;

  // z source: counter in the upper byte (bit 01 side), literal in the low byte
  assign z_src = {ctr_reg, opnd_reg[23:16]};
  always_comb begin
    case (mad_xsel_t'(ctrl_reg[CF_XSEL+:2]))
      MAD_XS_ACC3: x_op = acc3_reg;
      MAD_XS_ACC2: x_op = acc2_reg;
      MAD_XS_ACC1: x_op = acc1_reg;
      MAD_XS_Z: x_op = z_src;
      default: x_op = acc3_reg;
    endcase
  end
  // y source: operand word, or alt address zero-extended when operand bit 31 is set
  assign y_op = opnd_reg[31] ? {2'b00, alt_reg} : {opnd_reg[15:0]};

  assign fn.arith = ctrl_reg[CF_MODE];
  assign fn.fn = nano_reg[NB_FN_LO+:4];
  assign fn.inhibit = ctrl_reg[CF_INH];

  mad_adder u_adder (
    .i_x(x_op),
    .i_y(y_op),
    .i_fn(fn),
    .o_res(res)
  );

  mad_incr u_incr (
    .i_alt(alt_reg),
    .i_mpm(mpm_reg),
    .i_alt_plus(ctrl_reg[CF_APLS+:2]),
    .i_borc(ctrl_reg[CF_BORC]),
    .o_next(inc_next),
    .o_valid(inc_valid)
  );

  // barrel switch modelled as pass-through of the adder output
  assign barrel = res.sum;
  assign b_clk_en = |nano_reg[NB_BCLK_HI:NB_BCLK_LO];
  // bit n numbered from msb: bit 3 -> index 13 etc.
  assign comp_mask = ctrl_reg[CF_BC4] ? 16'h3333 : (ctrl_reg[CF_BC8] ? 16'h3030 : 16'h0000);

  // a micro step is a write to the control register
  assign step = wr_pend_reg && wr_addr_reg == ADDR_CTRL;

  // bus: zero wait states, writes captured from the data phase
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (i_hready) begin
      wr_pend_reg <= i_hsel && i_htrans == HTRANS_NONSEQ && i_hwrite;
      wr_addr_reg <= i_haddr[7:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RST;
      opnd_reg <= '0;
      nano_reg <= '0;
      mpm_reg <= '0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        ADDR_CTRL: ctrl_reg <= i_hwdata;
        ADDR_OPND: opnd_reg <= i_hwdata;
        ADDR_NANO_LO: nano_reg[31:0] <= i_hwdata;
        ADDR_NANO_HI: nano_reg[NANO_W-1:32] <= i_hwdata[NANO_W-33:0];
        ADDR_MPM: mpm_reg <= i_hwdata[ALT_W-1:0];
        default: ;
      endcase
    end
  end

  // datapath registers, clocked on each step
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acc1_reg <= '0;
      acc2_reg <= '0;
      acc3_reg <= '0;
      b_reg <= '0;
      mir_reg <= '0;
      mar_reg <= '0;
      sar_reg <= '0;
      base1_reg <= '0;
      base2_reg <= '0;
    end else if (step) begin
      acc1_reg <= i_hwdata[16] ? barrel : acc1_reg;
      acc2_reg <= i_hwdata[17] ? barrel : acc2_reg;
      acc3_reg <= i_hwdata[18] ? barrel : acc3_reg;
      mar_reg <= i_hwdata[19] ? barrel : mar_reg;
      sar_reg <= i_hwdata[20] ? barrel[SAR_W-1:0] : sar_reg;
      if (b_clk_en) begin
        b_reg <= barrel | (res.ovf ? 16'h0000 : comp_mask);
      end
      if (nano_reg[NB_MIR]) begin
        mir_reg <= barrel;
      end
      if (nano_reg[NB_BR1]) begin
        base1_reg <= barrel[15:8];
      end
      if (nano_reg[NB_BR2]) begin
        base2_reg <= barrel[15:8];
      end
    end
  end

  // counter: load from barrel low byte on bit 21, else increment on bit 22; overflow when counting past full
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctr_reg <= '0;
      cov_reg <= 1'b0;
    end else if (step && i_hwdata[21]) begin
      ctr_reg <= barrel[CTR_W-1:0];
      cov_reg <= 1'b0;
    end else if (step && i_hwdata[22]) begin
      ctr_reg <= ctr_reg + 8'h01;
      if (ctr_reg == CTR_FULL) begin
        cov_reg <= 1'b1;
      end
    end
  end

  // alternate address, increment and count registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      alt_reg <= '0;
      incr_reg <= '0;
      mpc_reg <= '0;
    end else if (step) begin
      if (i_hwdata[CF_ALTMP]) begin
        alt_reg <= mpm_reg;
      end else if (i_hwdata[CF_ALTMC]) begin
        alt_reg <= mpc_reg;
      end else if (nano_reg[NB_ALT]) begin
        alt_reg <= barrel[ALT_W-1:0];
      end
      if (inc_valid) begin
        incr_reg <= inc_next;
      end
      mpc_reg <= incr_reg;
    end
  end

  // condition flags from the adder, parity flag from the nanoword
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ovf_reg <= 1'b0;
      abt_reg <= 1'b0;
      shift_reg <= 1'b0;
      npe_reg <= 1'b0;
    end else if (step) begin
      ovf_reg <= res.ovf;
      abt_reg <= res.all_true;
      shift_reg <= res.sum[WORD_W-1] ^ res.sum[0];
      // sticky until the next step that checks parity
      if (i_hwdata[CF_TYPE1] || i_hwdata[CF_NTEST]) begin
        npe_reg <= ~(^nano_reg);
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (i_haddr[7:0])
      ADDR_CTRL: rd_data = ctrl_reg;
      ADDR_OPND: rd_data = opnd_reg;
      ADDR_RES: rd_data = {b_reg, res.sum};
      ADDR_STAT: rd_data = {24'h000000, shift_reg, res.sum[WORD_W-1], res.sum[0], b_clk_en,
        npe_reg, abt_reg, ovf_reg, cov_reg};
      ADDR_NANO_LO: rd_data = nano_reg[31:0];
      ADDR_NANO_HI: rd_data = {8'h00, nano_reg[NANO_W-1:32]};
      ADDR_ALT: rd_data = {2'b00, incr_reg, 2'b00, alt_reg};
      ADDR_MPM: rd_data = {2'b00, mpc_reg, 2'b00, mpm_reg};
      ADDR_CNT: rd_data = {base2_reg, base1_reg, ctr_reg, 2'b00, sar_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_hready && i_hsel && i_htrans == HTRANS_NONSEQ && !i_hwrite) begin
      o_hrdata <= rd_data;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule // mad_top
